/* File: verilog/lpc_sideband_pkg.sv */
// Purpose: shared constants for the sideband control and status block
// Assumes: 8-bit register port, 200 MHz core clock
// Notes: register offsets are word indices on the plain register port
`default_nettype none
package lpc_sideband_pkg;

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OUT_CTRL_ADDR = 2'h0;
  localparam logic [ADDR_W-1:0] STATUS_CTRL_ADDR = 2'h1;
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 2'h2;
  localparam logic [ADDR_W-1:0] EVT_MASK_ADDR = 2'h3;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int unsigned SB_N = 3;
  localparam int unsigned WAKE_BIT = 2;
  localparam int unsigned SMI_BIT = 1;
  localparam int unsigned CTRL_BIT = 0;
  localparam int unsigned XFER_BIT = 7;
  localparam int unsigned BUS_CLOCK_RESTART_REQUEST_BIT = 6;
  localparam int unsigned FRAME_BIT = 5;
  localparam int unsigned EV_N = 4;
  localparam int unsigned EV_XFER_START = 0;
  localparam int unsigned EV_XFER_END = 1;
  localparam int unsigned EV_BUS_CLOCK_RESTART_REQUEST = 2;
  localparam int unsigned EV_FRAME_END = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [SB_N-1:0] SB_RST = 3'h0;
  localparam logic [EV_N-1:0] EV_RST = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned LCLK_STOP_NS = 250;
  localparam int unsigned LCLK_STOP_CYC =
    (LCLK_STOP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STOP_CNT_W = 8;

endpackage : lpc_sideband_pkg
`default_nettype wire

/* File: verilog/link_status_if.sv */
// Purpose: carries synchronised link conditions from the monitor to the core
// Assumes: both ends on clk
// Notes: all members are registered by the monitor
`timescale 1ns/1ps
`default_nettype none
interface link_status_if;
  logic lclk_stopped;
  logic hw_reset;
  logic hw_shutdown;

  modport mon (output lclk_stopped, output hw_reset, output hw_shutdown);
  modport core (input lclk_stopped, input hw_reset, input hw_shutdown);
endinterface : link_status_if
`default_nettype wire

/* File: verilog/lclk_monitor.sv */
// Purpose: samples the link clock and link reset pins, finds a stopped clock
// Assumes: lclk, lreset_n and lpcpd_n are asynchronous to clk
// Notes: a stopped clock is seen only after a full quiet interval
`timescale 1ns/1ps
`default_nettype none
module lclk_monitor
  import lpc_sideband_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lclk,
  input wire logic lreset_n,
  input wire logic lpcpd_n,
  link_status_if.mon st
);

  localparam logic [STOP_CNT_W-1:0] STOP_CNT = STOP_CNT_W'(LCLK_STOP_CYC);

  logic lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
  logic lrst_s1_ff, lrst_s2_ff;
  logic lpd_s1_ff, lpd_s2_ff;
  logic [STOP_CNT_W-1:0] quiet_cnt_ff;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lclk_s1_ff <= 1'b0;
      lclk_s2_ff <= 1'b0;
      lclk_s3_ff <= 1'b0;
    end
    else
    begin
      lclk_s1_ff <= lclk;
      lclk_s2_ff <= lclk_s1_ff;
      lclk_s3_ff <= lclk_s2_ff;
    end
  end

  // pins idle high; reset value keeps the link out of reset/shutdown
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lrst_s1_ff <= 1'b1;
      lrst_s2_ff <= 1'b1;
      lpd_s1_ff <= 1'b1;
      lpd_s2_ff <= 1'b1;
    end
    else
    begin
      lrst_s1_ff <= lreset_n;
      lrst_s2_ff <= lrst_s1_ff;
      lpd_s1_ff <= lpcpd_n;
      lpd_s2_ff <= lpd_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // quiet interval counter, restarted by each rising lclk edge
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_cnt_ff <= '0;
    else if (lclk_s2_ff && !lclk_s3_ff)
      quiet_cnt_ff <= '0;
    else if (quiet_cnt_ff != STOP_CNT)
      quiet_cnt_ff <= quiet_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.lclk_stopped <= 1'b0;
      st.hw_reset <= 1'b0;
      st.hw_shutdown <= 1'b0;
    end
    else
    begin
      st.lclk_stopped <= (quiet_cnt_ff == STOP_CNT);
      st.hw_reset <= !lrst_s2_ff;
      st.hw_shutdown <= !lpd_s2_ff;
    end
  end

endmodule : lclk_monitor
`default_nettype wire

/* File: verilog/lpc_sideband_status_ctrl.sv */
// Purpose: firmware control of three open-drain sideband pins and status flags
// Assumes: cycle and serial-interrupt events arrive as clk-domain pulses
// Notes: registers are reached over a plain port with read data one cycle later
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - wake enable 0 hands pin to other function; enabled: low for 0, float for 1
// - sys-mgmt irq enable 0 leaves alternate function; else low for 0, float for 1
// - ctrl irq enable 0 keeps other function; else low for 0, float for 1
// - sideband pins open-drain: only pull low or release; board supplies pull-up
// - transfer flag bit 7 sets on handled cycle type and address match
// - transfer flag clears when handled cycle ends normally or is aborted
// - transfer flag reads 0 when idle, unaddressed, or type/address unknown
// - link reset or shutdown, hardware or software, clears all three flags
// - clock-restart flag bit 6 sets: quiet mode, clock stopped, irq to send
// - clock-restart flag clears: no irq left, quiet mode, continuous mode
// - frame flag bit 5 sets at serial-irq frame start, clears at its end
// - three level bits sit at 2..0 of status register, read/write, reset 0
module lpc_sideband_status_ctrl
  import lpc_sideband_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic lclk,
  input wire logic lreset_n,
  input wire logic lpcpd_n,
  input wire logic lpc_sw_reset,
  input wire logic lpc_sw_shutdown,
  input wire logic cycle_match,
  input wire logic cycle_done,
  input wire logic cycle_abort,
  input wire logic serirq_frame_start,
  input wire logic serirq_frame_end,
  input wire logic serirq_quiet_mode,
  input wire logic serirq_continuous,
  input wire logic serirq_irq_pending,
  output logic [SB_N-1:0] sideband_pin_out,
  output logic [SB_N-1:0] sideband_pin_oe,
  output logic [SB_N-1:0] sideband_alt_func,
  output logic bus_clock_restart_request,
  output logic irq
);

  link_status_if st ();

  lclk_monitor u_mon (
    .clk(clk),
    .rst_n(rst_n),
    .lclk(lclk),
    .lreset_n(lreset_n),
    .lpcpd_n(lpcpd_n),
    .st(st)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction : hit

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [SB_N-1:0] out_enable_ff;
  logic [SB_N-1:0] out_level_ff;
  logic [EV_N-1:0] evt_status_ff;
  logic [EV_N-1:0] evt_mask_ff;
  logic [EV_N-1:0] evt_set;
  logic [EV_N-1:0] nxt_evt_status;
  logic transfer_in_progress_ff;
  logic clk_restart_ff;
  logic serial_irq_frame_active_ff;
  logic lpc_clear;
  logic bus_clock_restart_request_set;
  logic bus_clock_restart_request_clr;
  logic wr_out, wr_stat, wr_evt, wr_mask;

  assign wr_out = reg_wr && hit(reg_addr, OUT_CTRL_ADDR);
  assign wr_stat = reg_wr && hit(reg_addr, STATUS_CTRL_ADDR);
  assign wr_evt = reg_wr && hit(reg_addr, EVT_STATUS_ADDR);
  assign wr_mask = reg_wr && hit(reg_addr, EVT_MASK_ADDR);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_enable_ff <= SB_RST;
    else if (wr_out)
      out_enable_ff <= reg_wdata[SB_N-1:0];
  end

  // flag bits in the same byte are ignored on write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      out_level_ff <= SB_RST;
    else if (wr_stat)
      out_level_ff <= reg_wdata[SB_N-1:0];
  end

  // ---------------------------------------------------------------
  // open-drain pins
  // ---------------------------------------------------------------
  // data is always low; only the enable moves, so the pin never drives high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sideband_pin_out <= SB_RST;
      sideband_pin_oe <= SB_RST;
      sideband_alt_func <= ~SB_RST;
    end
    else
    begin
      sideband_pin_out <= SB_RST;
      sideband_pin_oe <= out_enable_ff & ~out_level_ff;
      sideband_alt_func <= ~out_enable_ff;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  assign lpc_clear = st.hw_reset || lpc_sw_reset || st.hw_shutdown || lpc_sw_shutdown;

  // a new match in the same cycle as an end belongs to the next cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      transfer_in_progress_ff <= 1'b0;
    else if (lpc_clear)
      transfer_in_progress_ff <= 1'b0;
    else if (cycle_match)
      transfer_in_progress_ff <= 1'b1;
    else if (cycle_done || cycle_abort)
      transfer_in_progress_ff <= 1'b0;
  end

  assign bus_clock_restart_request_set = serirq_quiet_mode && st.lclk_stopped && serirq_irq_pending;
  assign bus_clock_restart_request_clr = serirq_quiet_mode && serirq_continuous && !serirq_irq_pending;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      clk_restart_ff <= 1'b0;
    else if (lpc_clear)
      clk_restart_ff <= 1'b0;
    else if (bus_clock_restart_request_set)
      clk_restart_ff <= 1'b1;
    else if (bus_clock_restart_request_clr)
      clk_restart_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      serial_irq_frame_active_ff <= 1'b0;
    else if (lpc_clear)
      serial_irq_frame_active_ff <= 1'b0;
    else if (serirq_frame_start)
      serial_irq_frame_active_ff <= 1'b1;
    else if (serirq_frame_end)
      serial_irq_frame_active_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_clock_restart_request <= 1'b0;
    else
      bus_clock_restart_request <= clk_restart_ff;
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  always_comb
  begin
    evt_set = EV_RST;
    evt_set[EV_XFER_START] = !lpc_clear && cycle_match && !transfer_in_progress_ff;
    evt_set[EV_XFER_END] = !lpc_clear && !cycle_match && transfer_in_progress_ff
      && (cycle_done || cycle_abort);
    evt_set[EV_BUS_CLOCK_RESTART_REQUEST] = !lpc_clear && bus_clock_restart_request_set && !clk_restart_ff;
    evt_set[EV_FRAME_END] = !lpc_clear && !serirq_frame_start && serirq_frame_end
      && serial_irq_frame_active_ff;
  end

  // set beats a write-one clear landing in the same cycle
  always_comb
  begin
    nxt_evt_status = evt_status_ff;
    if (wr_evt)
      nxt_evt_status = evt_status_ff & ~reg_wdata[EV_N-1:0];
    nxt_evt_status = nxt_evt_status | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_status_ff <= EV_RST;
    else
      evt_status_ff <= nxt_evt_status;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_mask_ff <= EV_RST;
    else if (wr_mask)
      evt_mask_ff <= reg_wdata[EV_N-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      // the mask being written this cycle counts, so irq never lags a mask change
      irq <= |(nxt_evt_status & (wr_mask ? reg_wdata[EV_N-1:0] : evt_mask_ff));
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // data outside a read cycle returns to zero so stale values never linger
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= DATA_RST;
    else
    begin
      reg_rdata <= DATA_RST;
      if (reg_rd)
      begin
        unique case (reg_addr)
          OUT_CTRL_ADDR: reg_rdata[SB_N-1:0] <= out_enable_ff;
          STATUS_CTRL_ADDR:
          begin
            reg_rdata[XFER_BIT] <= transfer_in_progress_ff;
            reg_rdata[BUS_CLOCK_RESTART_REQUEST_BIT] <= clk_restart_ff;
            reg_rdata[FRAME_BIT] <= serial_irq_frame_active_ff;
            reg_rdata[SB_N-1:0] <= out_level_ff;
          end
          EVT_STATUS_ADDR: reg_rdata[EV_N-1:0] <= evt_status_ff;
          EVT_MASK_ADDR: reg_rdata[EV_N-1:0] <= evt_mask_ff;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wake_pin_a: assert property (
    out_enable_ff[WAKE_BIT] |=> !sideband_alt_func[WAKE_BIT]
      && (sideband_pin_oe[WAKE_BIT] == !$past(out_level_ff[WAKE_BIT])))
    else $error("wake pin drive does not follow enable and level");

  smi_pin_a: assert property (
    !out_enable_ff[SMI_BIT] |=> sideband_alt_func[SMI_BIT] && !sideband_pin_oe[SMI_BIT])
    else $error("disabled sys-mgmt pin not given to alternate function");

  ctrl_pin_a: assert property (
    wr_out && reg_wdata[CTRL_BIT] && !wr_stat && !out_level_ff[CTRL_BIT]
      |=> ##1 sideband_pin_oe[CTRL_BIT])
    else $error("enabled ctrl pin with level 0 not pulled low");

  open_drain_a: assert property (
    sideband_pin_out == SB_RST)
    else $error("sideband pin data not low");

  busy_set_a: assert property (
    cycle_match && !lpc_clear |=> transfer_in_progress_ff)
    else $error("transfer flag not set on match");

  busy_end_a: assert property (
    transfer_in_progress_ff && (cycle_done || cycle_abort) && !cycle_match
      |=> !transfer_in_progress_ff)
    else $error("transfer flag not cleared at cycle end");

  busy_idle_a: assert property (
    !transfer_in_progress_ff && !cycle_match |=> !transfer_in_progress_ff)
    else $error("transfer flag set without a match");

  link_clear_a: assert property (
    lpc_clear |=> !transfer_in_progress_ff && !clk_restart_ff && !serial_irq_frame_active_ff)
    else $error("flags survive link reset or shutdown");

  bus_clock_restart_request_set_a: assert property (
    bus_clock_restart_request_set && !lpc_clear |=> clk_restart_ff ##1 bus_clock_restart_request)
    else $error("clock restart request not raised");

  bus_clock_restart_request_clr_a: assert property (
    bus_clock_restart_request_clr && !bus_clock_restart_request_set |=> !clk_restart_ff)
    else $error("clock restart request not dropped");

  frame_flag_a: assert property (
    serirq_frame_end && !serirq_frame_start |=> !serial_irq_frame_active_ff)
    else $error("frame flag not cleared at frame end");

  level_rw_a: assert property (
    wr_stat ##1 reg_rd && hit(reg_addr, STATUS_CTRL_ADDR)
      |=> reg_rdata[SB_N-1:0] == $past(reg_wdata[SB_N-1:0], 2))
    else $error("level bits do not read back");

  flags_ro_a: assert property (
    wr_stat && !lpc_clear && !cycle_match && !cycle_done && !cycle_abort
      |=> $stable(transfer_in_progress_ff))
    else $error("firmware write changed a read-only flag");

endmodule : lpc_sideband_status_ctrl
`default_nettype wire

/* File: dv/lpc_host_model.sv */
// Purpose: host-side model of the link pins and of the board pull-ups
// Assumes: link clock period 125 ns, phase unrelated to clk
// Notes: the link clock stands low while stopped
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model
(
  input wire logic run_clk,
  input wire logic hold_reset,
  input wire logic power_down,
  input wire logic [2:0] pin_oe,
  output logic lclk,
  output logic lreset_n,
  output logic lpcpd_n,
  output logic [2:0] pin_level
);
  // ---------------------------------------------------------------
  // link clock
  // ---------------------------------------------------------------
  initial
  begin
    lclk = 1'b0;
    #3.3;
    forever
    begin
      #62.5;
      lclk = run_clk ? ~lclk : 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  assign lreset_n = ~hold_reset;
  assign lpcpd_n = ~power_down;
  // a released line reads high only through the pull-up
  assign pin_level = ~pin_oe;
endmodule : lpc_host_model
`default_nettype wire

/* File: dv/test_lpc_sideband_status_ctrl.sv */
// Purpose: self-checking bench for the sideband control and status block
// Assumes: reads are checked by a monitor against a queue of notes
// Notes: pins are sampled at the falling edge, after updates have landed
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (e)); end end
module test_lpc_sideband_status_ctrl
  import lpc_sideband_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [4:0] ev = '0;
  logic [4:0] lv = '0;
  logic run_clk = 1'b1;
  logic hold_reset = 1'b0;
  logic power_down = 1'b0;
  logic lclk, lreset_n, lpcpd_n, restart, irq;
  logic [2:0] pin_out, pin_oe, alt, pin_level;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;

  always #2.5 clk = ~clk;

  lpc_sideband_status_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lclk(lclk), .lreset_n(lreset_n), .lpcpd_n(lpcpd_n), .lpc_sw_reset(lv[0]),
    .lpc_sw_shutdown(lv[1]), .cycle_match(ev[0]), .cycle_done(ev[1]),
    .cycle_abort(ev[2]), .serirq_frame_start(ev[3]), .serirq_frame_end(ev[4]),
    .serirq_quiet_mode(lv[2]), .serirq_continuous(lv[3]),
    .serirq_irq_pending(lv[4]), .sideband_pin_out(pin_out),
    .sideband_pin_oe(pin_oe), .sideband_alt_func(alt),
    .bus_clock_restart_request(restart), .irq(irq));

  lpc_host_model host (.run_clk(run_clk), .hold_reset(hold_reset),
    .power_down(power_down), .pin_oe(pin_oe), .lclk(lclk), .lreset_n(lreset_n),
    .lpcpd_n(lpcpd_n), .pin_level(pin_level));

  // ---------------------------------------------------------------
  // read monitor
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    logic [7:0] note;
    if (rd_seen)
    begin
      note = exp_q.pop_front();
      `CHK(reg_rdata, note)
    end
    rd_seen <= reg_rd;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic idle(input int n);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  // events are one-cycle pulses; the extra edge keeps drivers single per step
  task automatic pulse(input logic [4:0] m);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    ev <= m;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask : pulse

  task automatic peek(input logic [13:0] e);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    @(negedge clk);
    `CHK({alt, pin_oe, pin_level, pin_out, irq, restart}, e)
    @(posedge clk);
  endtask : peek

  function automatic logic [13:0] pv(input logic [2:0] en, input logic [2:0] lvl,
    input logic i, input logic r);
    return {~en, en & ~lvl, ~(en & ~lvl), 3'h0, i, r};
  endfunction : pv

  function automatic logic [7:0] st(input logic [2:0] f, input logic [2:0] lvl);
    return {f, 2'h0, lvl};
  endfunction : st

  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial
  begin
    #100000;
    mismatches++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    logic [2:0] en;
    logic [2:0] lvl;
    logic [7:0] d;
    d = DATA_W'($urandom(32'h27C1));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    peek(pv(3'h0, 3'h0, 1'b0, 1'b0));
    for (int i = 0; i < 4; i++)
      rd(i[1:0], 8'h00);
    // random enables and levels, flag bits written as ones must stay clear
    repeat (10)
    begin
      d = DATA_W'($urandom);
      en = d[2:0];
      lvl = d[5:3];
      wr(OUT_CTRL_ADDR, d);
      wr(STATUS_CTRL_ADDR, {3'h7, d[1:0], d[5:3]});
      rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
      peek(pv(en, lvl, 1'b0, 1'b0));
      rd(OUT_CTRL_ADDR, {5'h00, en});
    end
    wr(EVT_MASK_ADDR, 8'hFF);
    rd(EVT_MASK_ADDR, 8'h0F);
    pulse(5'h02);
    rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
    pulse(5'h01);
    rd(STATUS_CTRL_ADDR, st(3'h4, lvl));
    pulse(5'h03);
    rd(STATUS_CTRL_ADDR, st(3'h4, lvl));
    pulse(5'h02);
    rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
    rd(EVT_STATUS_ADDR, 8'h03);
    peek(pv(en, lvl, 1'b1, 1'b0));
    wr(EVT_STATUS_ADDR, 8'h03);
    idle(2);
    peek(pv(en, lvl, 1'b0, 1'b0));
    wr(EVT_MASK_ADDR, 8'h00);
    pulse(5'h01);
    pulse(5'h04);
    rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
    peek(pv(en, lvl, 1'b0, 1'b0));
    wr(EVT_STATUS_ADDR, 8'h0F);
    pulse(5'h08);
    rd(STATUS_CTRL_ADDR, st(3'h1, lvl));
    pulse(5'h10);
    rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
    rd(EVT_STATUS_ADDR, 8'h08);
    // a running link clock must not raise the restart request
    lv <= 5'h14;
    idle(80);
    rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
    run_clk <= 1'b0;
    idle(80);
    peek(pv(en, lvl, 1'b0, 1'b1));
    rd(STATUS_CTRL_ADDR, st(3'h2, lvl));
    rd(EVT_STATUS_ADDR, 8'h0C);
    lv <= 5'h1C;
    idle(4);
    rd(STATUS_CTRL_ADDR, st(3'h2, lvl));
    lv <= 5'h0C;
    idle(4);
    rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
    peek(pv(en, lvl, 1'b0, 1'b0));
    lv <= 5'h00;
    run_clk <= 1'b1;
    lvl = 3'h0;
    wr(STATUS_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      pulse(5'h01);
      pulse(5'h08);
      rd(STATUS_CTRL_ADDR, st(3'h5, lvl));
      lv[0] <= (k == 0);
      lv[1] <= (k == 1);
      hold_reset <= (k == 2);
      power_down <= (k == 3);
      idle(8);
      rd(STATUS_CTRL_ADDR, st(3'h0, lvl));
      lv[1:0] <= 2'h0;
      hold_reset <= 1'b0;
      power_down <= 1'b0;
      idle(8);
    end
    idle(3);
    finish_test();
  end
endmodule : test_lpc_sideband_status_ctrl
`default_nettype wire
